// *** shared/pcs_pkg.sv ***
// ----------------------------------------------------------------
// Constants for the configuration and strap pin block
// ----------------------------------------------------------------
package pcs_pkg;

   // Register byte offsets on the Wishbone bus
   localparam logic [7:0] PCS_CTRL_OFS = 8'h00;  // Software-mode settings
   localparam logic [7:0] PCS_STAT_OFS = 8'h04;  // Live pin and strap state

   // Field positions, shared by both registers where they overlap
   localparam int PCS_B_SPEED = 0;  // 1 = 100Base-TX
   localparam int PCS_B_AN    = 1;  // 1 = auto-negotiation enabled
   localparam int PCS_B_DPX   = 2;  // 1 = full duplex
   localparam int PCS_B_MODE  = 3;  // 1 = software mode
   localparam int PCS_B_ADDR4 = 4;  // Captured address bit 4
   localparam int PCS_B_DONE  = 5;  // Strap captured, LED driving
   localparam int PCS_B_LED   = 6;  // Receive LED level on the pin

   // Number of mode-dependent select pins
   localparam int PCS_NSEL = 3;

   // Reset values of the software-mode settings
   localparam logic PCS_RST_SPEED = 1'b1;
   localparam logic PCS_RST_AN    = 1'b1;
   localparam logic PCS_RST_DPX   = 1'b0;

   // Phase of the multiplexed address/LED pin
   typedef enum logic [0:0] {
      PCS_ST_SAMPLE = 1'b0,  // Input, strap being sampled
      PCS_ST_DRIVE  = 1'b1   // Output, driving the LED
   } pcs_strap_st_t;

endpackage

// *** design/pcs_strap_latch.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Address bit 4 strap capture and receive LED driver
// ----------------------------------------------------------------
module pcs_strap_latch (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Multiplexed pin
   input  wire logic pin_i,
   output logic      pin_o,
   output logic      pin_oe,
   // Core side
   input  wire logic rx_activity,
   output logic      addr4,
   output logic      done
);

   pcs_pkg::pcs_strap_st_t state_reg;  // Pin phase
   logic                   addr4_reg;  // Latched strap bit
   logic                   pin_o_reg;  // LED level
   logic                   pin_oe_reg; // LED driver enable

   wire sampling = (state_reg == pcs_pkg::PCS_ST_SAMPLE);

   // Reset holds the pin as an input; the first edge after release
   // catches the strap, then the pin becomes the LED output.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg  <= pcs_pkg::PCS_ST_SAMPLE;
         addr4_reg  <= 1'b0;
         pin_o_reg  <= 1'b0;
         pin_oe_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            pcs_pkg::PCS_ST_SAMPLE: begin
               // Board keeps the strap at a defined level here
               addr4_reg  <= pin_i;
               state_reg  <= pcs_pkg::PCS_ST_DRIVE;
               pin_oe_reg <= 1'b1;
               pin_o_reg  <= rx_activity;
            end
            pcs_pkg::PCS_ST_DRIVE: begin
               pin_o_reg  <= rx_activity;
            end
         endcase
      end
   end

   assign pin_o  = pin_o_reg;
   assign pin_oe = pin_oe_reg;
   assign addr4  = addr4_reg;
   assign done   = (state_reg == pcs_pkg::PCS_ST_DRIVE);

   // Driver stays off until the strap is taken
   chk_strap_oe_off: assert property (@(posedge clk) disable iff (!rstn)
      sampling |-> !pin_oe_reg)
      else $error("strap pin driven before capture");

   // Captured bit equals the pin level of the capture edge; the release
   // edge itself still resets the flops, so it starts no attempt
   chk_strap_capture: assert property (@(posedge clk) disable iff (!rstn)
      (rstn && sampling) |=> (addr4_reg == $past(pin_i)))
      else $error("strap bit not captured from pin");

   // Captured bit holds until the next reset
   chk_addr4_hold: assert property (@(posedge clk) disable iff (!rstn)
      (!sampling && $past(!sampling)) |-> $stable(addr4_reg))
      else $error("address bit 4 changed after capture");

   // After capture the pin drives the LED level
   chk_led_drive: assert property (@(posedge clk) disable iff (!rstn)
      !sampling |=> (pin_oe_reg && pin_o_reg == $past(rx_activity)))
      else $error("receive LED not driven");

endmodule

// *** design/pcs_sel_pin.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// One mode-dependent select pin: input in hardware mode,
// status output in software mode
// ----------------------------------------------------------------
module pcs_sel_pin (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Mode and software setting
   input  wire logic mode_sw,
   input  wire logic sw_value,
   // Pin
   input  wire logic pin_i,
   output logic      pin_o,
   output logic      pin_oe,
   // Effective setting for the core
   output logic      value
);

   logic pin_o_reg;   // Level driven in software mode
   logic pin_oe_reg;  // Driver enable
   logic value_reg;   // Setting in force

   // Next values: same encoding in both directions
   wire pin_o_next  = mode_sw & sw_value;
   wire value_next  = mode_sw ? sw_value : pin_i;

   // Direction and value follow the mode each cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_o_reg  <= 1'b0;
         pin_oe_reg <= 1'b0;  // Input while in reset
         value_reg  <= 1'b0;
      end else begin
         pin_oe_reg <= mode_sw;
         pin_o_reg  <= pin_o_next;
         value_reg  <= value_next;
      end
   end

   assign pin_o  = pin_o_reg;
   assign pin_oe = pin_oe_reg;
   assign value  = value_reg;

   // Hardware mode: pin is an input and sets the value
   chk_hw_input: assert property (@(posedge clk) disable iff (!rstn)
      (rstn && !mode_sw) |=> (!pin_oe_reg && value_reg == $past(pin_i)))
      else $error("select pin not an input in hardware mode");

   // Software mode: pin shows the software setting
   chk_sw_output: assert property (@(posedge clk) disable iff (!rstn)
      mode_sw |=> (pin_oe_reg && pin_o_reg == $past(sw_value)
                   && value_reg == pin_o_reg))
      else $error("select pin not showing setting in software mode");

endmodule

// *** design/pcs_phy_cfg_pins.sv ***
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Configuration pin direction, strap capture and register slave
// ----------------------------------------------------------------
module pcs_phy_cfg_pins (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Hardware/software mode select
   input  wire logic        mode_select_a,
   // Address bit 4 / receive LED pin
   input  wire logic        addr4_rx_led_pin_i,
   output logic             addr4_rx_led_pin_o,
   output logic             addr4_rx_led_pin_oe,
   // Speed select pin
   input  wire logic        speed_select_pin_i,
   output logic             speed_select_pin_o,
   output logic             speed_select_pin_oe,
   // Auto-negotiation select pin
   input  wire logic        autoneg_select_pin_i,
   output logic             autoneg_select_pin_o,
   output logic             autoneg_select_pin_oe,
   // Duplex select pin
   input  wire logic        duplex_select_pin_i,
   output logic             duplex_select_pin_o,
   output logic             duplex_select_pin_oe,
   // Core side
   input  wire logic        rx_activity,
   output logic             phy_addr4,
   output logic             strap_done,
   output logic             sw_mode,
   output logic             speed_100,
   output logic             autoneg_en,
   output logic             full_duplex
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------

   logic                          mode_sw_reg;  // Registered mode pin
   logic [pcs_pkg::PCS_NSEL-1:0]  ctrl_reg;     // Software settings
   logic [pcs_pkg::PCS_NSEL-1:0]  ctrl_next;    // Their next value
   logic                          ack_reg;      // Bus acknowledge
   logic [31:0]                   dat_reg;      // Read data
   logic [31:0]                   ctrl_word;    // Control read view
   logic [31:0]                   stat_word;    // Status read view

   // Select pins gathered for the per-pin loop
   logic [pcs_pkg::PCS_NSEL-1:0]  sel_pin_i;    // Pin levels
   logic [pcs_pkg::PCS_NSEL-1:0]  sel_pin_o;    // Driven levels
   logic [pcs_pkg::PCS_NSEL-1:0]  sel_pin_oe;   // Driver enables
   logic [pcs_pkg::PCS_NSEL-1:0]  sel_value;    // Settings in force

   // Strap and LED state
   logic                          strap_addr4;  // Captured bit
   logic                          strap_drive;  // LED phase

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------

   // Request present on the bus
   wire wb_req   = wb_cyc_i & wb_stb_i;

   // Register hits
   wire hit_ctrl = (wb_adr_i == pcs_pkg::PCS_CTRL_OFS);
   wire hit_stat = (wb_adr_i == pcs_pkg::PCS_STAT_OFS);

   // New request not yet answered
   wire wb_start = wb_req & ~ack_reg;

   // Write commits on the edge where the master sees ack
   wire ctrl_wr  = wb_req & ack_reg & wb_we_i & hit_ctrl & wb_sel_i[0];

   // Read data, zero for unmapped offsets
   wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                        hit_stat ? stat_word : 32'h0000_0000;

   // Control register next value; only the low byte lane holds data
   assign ctrl_next = ctrl_wr ? wb_dat_i[pcs_pkg::PCS_NSEL-1:0] : ctrl_reg;

   // ----------------------------------------------------------------
   // Register read views
   // ----------------------------------------------------------------

   // Control view: settings used in software mode
   always_comb begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[pcs_pkg::PCS_B_SPEED] = ctrl_reg[pcs_pkg::PCS_B_SPEED];
      ctrl_word[pcs_pkg::PCS_B_AN]    = ctrl_reg[pcs_pkg::PCS_B_AN];
      ctrl_word[pcs_pkg::PCS_B_DPX]   = ctrl_reg[pcs_pkg::PCS_B_DPX];
   end

   // Status view: settings in force and strap state
   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[pcs_pkg::PCS_B_SPEED] = sel_value[pcs_pkg::PCS_B_SPEED];
      stat_word[pcs_pkg::PCS_B_AN]    = sel_value[pcs_pkg::PCS_B_AN];
      stat_word[pcs_pkg::PCS_B_DPX]   = sel_value[pcs_pkg::PCS_B_DPX];
      stat_word[pcs_pkg::PCS_B_MODE]  = mode_sw_reg;
      stat_word[pcs_pkg::PCS_B_ADDR4] = strap_addr4;
      stat_word[pcs_pkg::PCS_B_DONE]  = strap_drive;
      stat_word[pcs_pkg::PCS_B_LED]   = addr4_rx_led_pin_o;
   end

   // ----------------------------------------------------------------
   // Bus slave registers
   // ----------------------------------------------------------------

   // Acknowledge one cycle after the request, drop it the next
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= wb_start;
      end
   end

   // Read data taken with the acknowledge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dat_reg <= 32'h0000_0000;
      end else if (wb_start) begin
         dat_reg <= rd_mux;
      end
   end

   // Software-mode settings
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg[pcs_pkg::PCS_B_SPEED] <= pcs_pkg::PCS_RST_SPEED;
         ctrl_reg[pcs_pkg::PCS_B_AN]    <= pcs_pkg::PCS_RST_AN;
         ctrl_reg[pcs_pkg::PCS_B_DPX]   <= pcs_pkg::PCS_RST_DPX;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ----------------------------------------------------------------
   // Mode select
   // ----------------------------------------------------------------

   // Low selects hardware mode, high selects software mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_sw_reg <= 1'b0;
      end else begin
         mode_sw_reg <= mode_select_a;
      end
   end

   // ----------------------------------------------------------------
   // Strap pin
   // ----------------------------------------------------------------

   // Reset holds the pin as input; release catches the strap
   pcs_strap_latch u_strap (
      .clk         (clk),
      .rstn        (rstn),
      .pin_i       (addr4_rx_led_pin_i),
      .pin_o       (addr4_rx_led_pin_o),
      .pin_oe      (addr4_rx_led_pin_oe),
      .rx_activity (rx_activity),
      .addr4       (strap_addr4),
      .done        (strap_drive)
   );

   // ----------------------------------------------------------------
   // Select pins
   // ----------------------------------------------------------------

   // Pin levels into the loop, in field order
   assign sel_pin_i[pcs_pkg::PCS_B_SPEED] = speed_select_pin_i;
   assign sel_pin_i[pcs_pkg::PCS_B_AN]    = autoneg_select_pin_i;
   assign sel_pin_i[pcs_pkg::PCS_B_DPX]   = duplex_select_pin_i;

   // One direction controller per pin
   for (genvar g = 0; g < pcs_pkg::PCS_NSEL; g++) begin : g_sel
      pcs_sel_pin u_sel (
         .clk      (clk),
         .rstn     (rstn),
         .mode_sw  (mode_sw_reg),
         .sw_value (ctrl_reg[g]),
         .pin_i    (sel_pin_i[g]),
         .pin_o    (sel_pin_o[g]),
         .pin_oe   (sel_pin_oe[g]),
         .value    (sel_value[g])
      );
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // Bus answer
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   // Select pin drivers
   assign speed_select_pin_o    = sel_pin_o[pcs_pkg::PCS_B_SPEED];
   assign speed_select_pin_oe   = sel_pin_oe[pcs_pkg::PCS_B_SPEED];
   assign autoneg_select_pin_o  = sel_pin_o[pcs_pkg::PCS_B_AN];
   assign autoneg_select_pin_oe = sel_pin_oe[pcs_pkg::PCS_B_AN];
   assign duplex_select_pin_o   = sel_pin_o[pcs_pkg::PCS_B_DPX];
   assign duplex_select_pin_oe  = sel_pin_oe[pcs_pkg::PCS_B_DPX];

   // Settings in force and strap state for the core
   assign speed_100   = sel_value[pcs_pkg::PCS_B_SPEED];
   assign autoneg_en  = sel_value[pcs_pkg::PCS_B_AN];
   assign full_duplex = sel_value[pcs_pkg::PCS_B_DPX];
   assign sw_mode     = mode_sw_reg;
   assign phy_addr4   = strap_addr4;
   assign strap_done  = strap_drive;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   // Mode follows the select input one cycle later; the release edge
   // still resets the flop, so it starts no attempt
   chk_mode_follow: assert property (@(posedge clk) disable iff (!rstn)
      rstn |=> (mode_sw_reg == $past(mode_select_a)))
      else $error("mode does not follow mode select");

   // Hardware mode: speed taken from its pin
   chk_hw_speed: assert property (@(posedge clk) disable iff (!rstn)
      (rstn && !mode_sw_reg) |=> (!speed_select_pin_oe
                        && speed_100 == $past(speed_select_pin_i)))
      else $error("speed pin not an input in hardware mode");

   // Hardware mode: duplex taken from its pin
   chk_hw_duplex: assert property (@(posedge clk) disable iff (!rstn)
      (rstn && !mode_sw_reg) |=> (!duplex_select_pin_oe
                        && full_duplex == $past(duplex_select_pin_i)))
      else $error("duplex pin not an input in hardware mode");

   // Software mode: speed pin shows the setting
   chk_sw_speed: assert property (@(posedge clk) disable iff (!rstn)
      mode_sw_reg |=> (speed_select_pin_oe
         && speed_select_pin_o == $past(ctrl_reg[pcs_pkg::PCS_B_SPEED])))
      else $error("speed pin not showing speed");

   // Software mode: half duplex drives the pin low
   chk_sw_duplex: assert property (@(posedge clk) disable iff (!rstn)
      (mode_sw_reg && !ctrl_reg[pcs_pkg::PCS_B_DPX])
         |=> (duplex_select_pin_oe && !duplex_select_pin_o))
      else $error("duplex pin not low for half duplex");

   // Software mode: full duplex and 100 drive the pins high
   chk_sw_high: assert property (@(posedge clk) disable iff (!rstn)
      (mode_sw_reg && ctrl_reg[pcs_pkg::PCS_B_DPX]
                   && ctrl_reg[pcs_pkg::PCS_B_SPEED])
         |=> (duplex_select_pin_o && speed_select_pin_o))
      else $error("pin encoding differs from hardware mode");

   // Every new request is answered next cycle, for one cycle
   chk_ack_once: assert property (@(posedge clk) disable iff (!rstn)
      wb_start |=> (ack_reg ##1 !ack_reg))
      else $error("acknowledge not a single cycle");

   // A control write lands in the settings
   chk_ctrl_write: assert property (@(posedge clk) disable iff (!rstn)
      ctrl_wr |=> (ctrl_reg == $past(wb_dat_i[pcs_pkg::PCS_NSEL-1:0])))
      else $error("control write lost");

endmodule

// *** dv/pcs_board_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Board side: strap resistors, LED and pin wire resolution
// ----------------------------------------------------------------
module pcs_board_model (
   // Board-side levels set by the bench
   input  wire logic strap_lvl,
   input  wire logic hw_spd,
   input  wire logic hw_an,
   input  wire logic hw_dpx,
   // Device pin drivers
   input  wire logic a_o,
   input  wire logic a_oe,
   input  wire logic s_o,
   input  wire logic s_oe,
   input  wire logic n_o,
   input  wire logic n_oe,
   input  wire logic d_o,
   input  wire logic d_oe,
   // Resolved wire levels
   output logic      a_w,
   output logic      s_w,
   output logic      n_w,
   output logic      d_w
);
   // Strap resistor always holds a defined level; device wins when driving
   assign a_w = a_oe ? a_o : strap_lvl;
   // Select pins are tied by straps, overridden while the device drives
   assign s_w = s_oe ? s_o : hw_spd;
   assign n_w = n_oe ? n_o : hw_an;
   assign d_w = d_oe ? d_o : hw_dpx;
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bench for the configuration and strap pin block
// ----------------------------------------------------------------
module tb;
   logic        clk, rstn, cyc, stb, we, mode, rx_act, strap, hw_s, hw_n, hw_d;
   logic [7:0]  adr;                  // Byte address
   logic [3:0]  sel;                  // Byte enables
   logic [31:0] dat_w, dat_r, q;      // Write data, read data, task result
   logic        ack, a_o, a_oe, s_o, s_oe, n_o, n_oe, d_o, d_oe, a_w, s_w, n_w, d_w;
   logic        addr4, done, swm, spd, an, dpx;
   int          failures = 0;         // Mismatch count
   int          compares = 0;         // Comparison count

   pcs_phy_cfg_pins pcs_phy_cfg_pins_inst (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
      .wb_dat_o(dat_r), .wb_ack_o(ack), .mode_select_a(mode), .addr4_rx_led_pin_i(a_w),
      .addr4_rx_led_pin_o(a_o), .addr4_rx_led_pin_oe(a_oe), .speed_select_pin_i(s_w),
      .speed_select_pin_o(s_o), .speed_select_pin_oe(s_oe), .autoneg_select_pin_i(n_w),
      .autoneg_select_pin_o(n_o), .autoneg_select_pin_oe(n_oe),
      .duplex_select_pin_i(d_w), .duplex_select_pin_o(d_o), .duplex_select_pin_oe(d_oe),
      .rx_activity(rx_act), .phy_addr4(addr4), .strap_done(done), .sw_mode(swm),
      .speed_100(spd), .autoneg_en(an), .full_duplex(dpx));

   pcs_board_model pcs_board_model_inst (.strap_lvl(strap), .hw_spd(hw_s), .hw_an(hw_n),
      .hw_dpx(hw_d), .a_o(a_o), .a_oe(a_oe), .s_o(s_o), .s_oe(s_oe), .n_o(n_o),
      .n_oe(n_oe), .d_o(d_o), .d_oe(d_oe), .a_w(a_w), .s_w(s_w), .n_w(n_w), .d_w(d_w));

   // ----------------------------------------------------------------
   // Clock, verdict and comparison helpers
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task results;
      if (failures == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Compare one value and report a mismatch
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Expected status word from its fields
   function automatic logic [31:0] stat(input logic [2:0] cfg, input logic m, a4, dn, ld);
      stat = {25'h0, ld, dn, a4, m, cfg};
   endfunction

   // One classic Wishbone cycle, held until ack is sampled high
   // A missing ack is left to the watchdog
   task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat_w <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask

   // Let a few edges pass, then look at settled outputs
   task settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // Watchdog: the whole sequence needs well under 2000 cycles
   initial begin
      #(5000 * 50);
      failures++;
      results();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
      dat_w = 32'h0; mode = 1'b0; rx_act = 1'b0; strap = 1'b1;
      hw_s = 1'b0; hw_n = 1'b0; hw_d = 1'b0;
      // Reset: every pin is an input
      repeat (3) @(posedge clk);
      chk("oe_in_reset", 4'h0, {a_oe, s_oe, n_oe, d_oe});
      rstn <= 1'b1;
      settle(2);
      chk("phy_addr4", 1'b1, addr4);
      chk("led_oe", 1'b1, a_oe);
      chk("strap_done", 1'b1, done);
      chk("led_pin_off", 1'b0, a_w);
      // LED follows receive activity once driving
      @(posedge clk);
      rx_act <= 1'b1;
      strap <= 1'b0;
      settle(2);
      chk("led_pin", 1'b1, a_w);
      chk("phy_addr4_hold", 1'b1, addr4);
      // Hardware mode: every strap combination on the select pins
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         hw_s <= k[0]; hw_n <= k[1]; hw_d <= k[2];
         settle(3);
         chk("speed_100", k[0], spd);
         chk("autoneg_en", k[1], an);
         chk("full_duplex", k[2], dpx);
         chk("hw_oe", 3'h0, {s_oe, n_oe, d_oe});
         wb(1'b0, pcs_pkg::PCS_STAT_OFS, 4'hf, 32'h0);
         chk("stat_hw", stat(k[2:0], 1'b0, 1'b1, 1'b1, 1'b1), q);
      end
      // Software mode: control reset value, then every setting
      @(posedge clk);
      mode <= 1'b1;
      wb(1'b0, pcs_pkg::PCS_CTRL_OFS, 4'hf, 32'h0);
      chk("ctrl_reset", 32'h3, q);
      for (int k = 0; k < 8; k++) begin
         wb(1'b1, pcs_pkg::PCS_CTRL_OFS, 4'h1, k);
         hw_s <= ~k[0]; hw_n <= ~k[1]; hw_d <= ~k[2];
         settle(3);
         chk("speed_pin", k[0], s_w);
         chk("autoneg_pin", k[1], n_w);
         chk("duplex_pin", k[2], d_w);
         chk("sw_oe", 3'h7, {s_oe, n_oe, d_oe});
         chk("sw_cfg", k[2:0], {dpx, an, spd});
         chk("sw_mode", 1'b1, swm);
      end
      // Refused accesses: low byte lane not enabled, status write; then the status read back
      wb(1'b1, pcs_pkg::PCS_CTRL_OFS, 4'he, 32'h0);
      wb(1'b1, pcs_pkg::PCS_STAT_OFS, 4'hf, 32'h0);
      wb(1'b0, pcs_pkg::PCS_STAT_OFS, 4'hf, 32'h0);
      chk("stat_sw", stat(3'h7, 1'b1, 1'b1, 1'b1, 1'b1), q);
      // Zeros to an unmapped place must not reach the settings
      wb(1'b1, 8'h08, 4'hf, 32'h0);
      wb(1'b0, 8'h08, 4'hf, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(1'b0, pcs_pkg::PCS_CTRL_OFS, 4'hf, 32'h0);
      chk("ctrl_kept", 32'h7, q);
      // Second reset with the strap low, still in software mode
      @(posedge clk);
      rstn <= 1'b0;
      settle(2);
      chk("oe_in_reset2", 4'h0, {a_oe, s_oe, n_oe, d_oe});
      @(posedge clk);
      rstn <= 1'b1;
      settle(2);
      chk("phy_addr4_2", 1'b0, addr4);
      wb(1'b0, pcs_pkg::PCS_CTRL_OFS, 4'hf, 32'h0);
      chk("ctrl_reset2", 32'h3, q);
      results();
   end
endmodule
